/* rtl/pfdec_pkg.sv */
// Package: constants for the PWM fault, disable and enable control block
`default_nettype none
package pfdec_pkg;
	localparam int PFDEC_NPWM = 6;
	// Register indices on the plain register port
	localparam logic [2:0] PFDEC_REG_CTRL = 3'h0;
	localparam logic [2:0] PFDEC_REG_FCTL = 3'h1;
	localparam logic [2:0] PFDEC_REG_FSTAT = 3'h2;
	localparam logic [2:0] PFDEC_REG_FACK = 3'h3;
	localparam logic [2:0] PFDEC_REG_OUT = 3'h4;
	localparam logic [2:0] PFDEC_REG_MAP = 3'h5;
	localparam logic [2:0] PFDEC_REG_MOD = 3'h6;
	localparam logic [2:0] PFDEC_REG_DUTY = 3'h7;
	// Control register fields
	localparam int PFDEC_CTL_EN = 0;
	localparam int PFDEC_CTL_BUFFERED_LOAD_PERMIT = 1;
	localparam int PFDEC_CTL_RIE = 2;
	localparam int PFDEC_CTL_RFLAG = 3;
	localparam int PFDEC_CTL_CSENSE = 4;
	localparam int PFDEC_CTL_COMPL = 5;
	localparam int PFDEC_CTL_BANK_X_SOFT_DISABLE = 6;
	localparam int PFDEC_CTL_BANK_Y_SOFT_DISABLE = 7;
	// Fault control fields: mode and irq enable for input 1 and input 4
	localparam int PFDEC_FC_MODE1 = 0;
	localparam int PFDEC_FC_IE1 = 1;
	localparam int PFDEC_FC_MODE4 = 2;
	localparam int PFDEC_FC_IE4 = 3;
	// Fault status fields
	localparam int PFDEC_FS_LVL1 = 0;
	localparam int PFDEC_FS_FLAG1 = 1;
	localparam int PFDEC_FS_LVL4 = 2;
	localparam int PFDEC_FS_FLAG4 = 3;
	// Output register: bits 5:0 manual bits, bit 6 override
	localparam int PFDEC_OUT_OVR = 6;
	localparam logic [5:0] PFDEC_MAP_RESET = 6'h00;
	localparam logic [11:0] PFDEC_MOD_RESET = 12'h000;
	typedef enum logic [1:0] {PFDEC_F_ARM, PFDEC_F_IDLE, PFDEC_F_S1, PFDEC_F_HIGH} pfdec_filt_e;
endpackage : pfdec_pkg
`default_nettype wire

/* rtl/pfdec_top.sv */
// Fault protection, bank disables and module enable control for a six-output PWM
`default_nettype none
module pfdec_top
	import pfdec_pkg::*;
#(
	parameter int CNT_W = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Fault pins and shared port direction
	input wire logic fault1_pin,
	input wire logic fault4_pin,
	input wire logic [1:0] fault_shared_port_dir,
	// Top-side generator inputs for the pins (per output)
	input wire logic [5:0] gen_pwm,
	// Outputs
	output logic [5:0] pwm_out,
	output logic [5:0] pwm_oe,
	output logic cycle_start,
	output logic use_odd_values,
	output logic fault1_irq,
	output logic fault4_irq,
	output logic reload_irq
);

	logic [7:0] ctrl_q, ctrl_d;
	logic [3:0] fctl_q;
	logic [6:0] outr_q;
	logic [5:0] map_q;
	logic [11:0] mod_q, mod_act_q;
	logic [11:0] duty_q, duty_act_q;
	logic [CNT_W-1:0] cnt_q;
	logic en_prev_q, first_q;
	logic [1:0] s1_q, s2_q;
	pfdec_filt_e filt_q [2];
	logic [1:0] lvl_q, flag_q, irq_q, dis_q;
	logic [1:0] dsoft_q;
	logic [5:0] pwm_out_q, pwm_oe_q;
	logic cs_q, odd_q, rirq_q;
	logic [15:0] rdata_q;

	// Decodes
	wire wr_ctrl = reg_wr && (reg_addr == PFDEC_REG_CTRL);
	wire wr_fctl = reg_wr && (reg_addr == PFDEC_REG_FCTL);
	wire wr_fack = reg_wr && (reg_addr == PFDEC_REG_FACK);
	wire wr_out = reg_wr && (reg_addr == PFDEC_REG_OUT);
	wire wr_map = reg_wr && (reg_addr == PFDEC_REG_MAP);
	wire wr_mod = reg_wr && (reg_addr == PFDEC_REG_MOD);
	wire wr_duty = reg_wr && (reg_addr == PFDEC_REG_DUTY);
	wire module_enable_bit = ctrl_q[PFDEC_CTL_EN];
	wire manual_output_override = outr_q[PFDEC_OUT_OVR];
	wire en_rise = module_enable_bit && !en_prev_q;
	wire [1:0] ack = wr_fack ? {reg_wdata[PFDEC_FS_FLAG4], reg_wdata[PFDEC_FS_FLAG1]} : 2'h0;
	wire [1:0] fault_reenable_select = {fctl_q[PFDEC_FC_MODE4], fctl_q[PFDEC_FC_MODE1]};
	wire [1:0] fault_irq_enable = {fctl_q[PFDEC_FC_IE4], fctl_q[PFDEC_FC_IE1]};
	wire [1:0] raw_pin = {fault4_pin, fault1_pin};
	// Output-configured port pins read as non-fault
	wire [1:0] filt_in = s2_q & ~fault_shared_port_dir;
	wire cnt_wrap = (cnt_q >= CNT_W'(mod_act_q)) || (mod_act_q == 12'h000);
	wire load_now = en_rise || (module_enable_bit && cnt_wrap);
	// Re-enable evaluation point
	wire eval_pt = manual_output_override ? 1'b1 : cs_q;

	// Filter rise and level
	logic [1:0] rise;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			rise[i] = (filt_q[i] == PFDEC_F_S1) && filt_in[i];
		end
	end

	// Bank disable mapping: low three bits bank X, high three bank Y; an all-ones map lets either bank disable all six
	function automatic logic [5:0] pfdec_mask(input logic [5:0] m, input logic bx, input logic by);
		pfdec_mask = ({3'h0, m[2:0]} & {6{bx}}) | ({m[5:3], 3'h0} & {6{by}});
		if (m == 6'h3f) begin
			pfdec_mask = {6{bx | by}};
		end
	endfunction : pfdec_mask

	// Clearing conditions per bank
	logic [1:0] clr_ok;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			clr_ok[i] = fault_reenable_select[i] ? !lvl_q[i] : !flag_q[i];
		end
		clr_ok[1] = clr_ok[1] && (fault_reenable_select[1] || !filt_in[1]);
	end

	wire [5:0] dis_mask = pfdec_mask(map_q, dis_q[0] | dsoft_q[0], dis_q[1] | dsoft_q[1]);
	wire [5:0] src = manual_output_override ? outr_q[5:0] : (module_enable_bit ? gen_pwm : 6'h00);
	wire [5:0] oe_d = (module_enable_bit || manual_output_override) ? 6'h3f : 6'h00;

	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = reg_wdata[7:0];
			ctrl_d[PFDEC_CTL_RFLAG] = ctrl_q[PFDEC_CTL_RFLAG] & reg_wdata[PFDEC_CTL_RFLAG];
		end
		if (load_now) begin
			ctrl_d[PFDEC_CTL_RFLAG] = 1'b1;
			ctrl_d[PFDEC_CTL_BUFFERED_LOAD_PERMIT] = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= 2'h0;
			s2_q <= 2'h0;
		end else begin
			s1_q <= raw_pin;
			s2_q <= s1_q;
		end
	end

	// Fault filter, level, flag and interrupt latches
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			filt_q[0] <= PFDEC_F_ARM;
			filt_q[1] <= PFDEC_F_ARM;
			lvl_q <= 2'h0;
			flag_q <= 2'h0;
			irq_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				case (filt_q[i])
					PFDEC_F_ARM: filt_q[i] <= filt_in[i] ? PFDEC_F_ARM : PFDEC_F_IDLE;
					PFDEC_F_IDLE: filt_q[i] <= filt_in[i] ? PFDEC_F_S1 : PFDEC_F_IDLE;
					PFDEC_F_S1: filt_q[i] <= filt_in[i] ? PFDEC_F_HIGH : PFDEC_F_IDLE;
					PFDEC_F_HIGH: filt_q[i] <= filt_in[i] ? PFDEC_F_HIGH : PFDEC_F_ARM;
					default: filt_q[i] <= PFDEC_F_ARM;
				endcase
				if (rise[i]) begin
					lvl_q[i] <= 1'b1;
				end else if ((filt_q[i] == PFDEC_F_HIGH) && !filt_in[i]) begin
					lvl_q[i] <= 1'b0;
				end
				flag_q[i] <= rise[i] | (flag_q[i] & ~ack[i]);
				irq_q[i] <= (rise[i] & fault_irq_enable[i])
					| (irq_q[i] & ~ack[i] & fault_irq_enable[i]);
			end
		end
	end

	// Disable latches per bank
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dis_q <= 2'h0;
			dsoft_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (rise[i]) begin
					dis_q[i] <= 1'b1;
				end else if (eval_pt && clr_ok[i]) begin
					dis_q[i] <= 1'b0;
				end
			end
			if (ctrl_q[PFDEC_CTL_BANK_X_SOFT_DISABLE]) begin
				dsoft_q[0] <= 1'b1;
			end else if (eval_pt) begin
				dsoft_q[0] <= 1'b0;
			end
			if (ctrl_q[PFDEC_CTL_BANK_Y_SOFT_DISABLE]) begin
				dsoft_q[1] <= 1'b1;
			end else if (eval_pt) begin
				dsoft_q[1] <= 1'b0;
			end
		end
	end

	// Registers, counter and reload
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= 8'h00;
			fctl_q <= 4'h0;
			outr_q <= 7'h00;
			map_q <= PFDEC_MAP_RESET;
			mod_q <= PFDEC_MOD_RESET;
			mod_act_q <= PFDEC_MOD_RESET;
			duty_q <= 12'h000;
			duty_act_q <= 12'h000;
			cnt_q <= '0;
			en_prev_q <= 1'b0;
			first_q <= 1'b0;
			cs_q <= 1'b0;
			odd_q <= 1'b0;
			rirq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			en_prev_q <= module_enable_bit;
			if (wr_fctl) begin
				fctl_q <= reg_wdata[3:0];
			end
			if (wr_out) begin
				outr_q <= reg_wdata[6:0];
			end
			if (wr_map) begin
				map_q <= reg_wdata[5:0];
			end
			if (wr_mod) begin
				mod_q <= reg_wdata[11:0];
			end
			if (wr_duty) begin
				duty_q <= reg_wdata[11:0];
			end
			if (load_now && ctrl_q[PFDEC_CTL_BUFFERED_LOAD_PERMIT]) begin
				mod_act_q <= mod_q;
				duty_act_q <= duty_q;
			end
			if (!module_enable_bit) begin
				cnt_q <= '0;
			end else if (load_now) begin
				cnt_q <= CNT_W'(1);
			end else begin
				cnt_q <= cnt_q + CNT_W'(1);
			end
			cs_q <= load_now;
			if (en_rise) begin
				first_q <= 1'b1;
			end else if (load_now || !module_enable_bit) begin
				first_q <= 1'b0;
			end
			odd_q <= (en_rise || (first_q && !load_now))
				&& ctrl_q[PFDEC_CTL_COMPL] && ctrl_q[PFDEC_CTL_CSENSE];
			rirq_q <= ctrl_d[PFDEC_CTL_RFLAG] && ctrl_d[PFDEC_CTL_RIE];
		end
	end

	// Output stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pwm_out_q <= 6'h00;
			pwm_oe_q <= 6'h00;
		end else begin
			pwm_out_q <= src & ~dis_mask;
			pwm_oe_q <= oe_d;
		end
	end

	// Read data
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				PFDEC_REG_CTRL: rdata_q <= {8'h00, ctrl_q};
				PFDEC_REG_FCTL: rdata_q <= {12'h000, fctl_q};
				PFDEC_REG_FSTAT: rdata_q <= {12'h000, flag_q[1], lvl_q[1], flag_q[0], lvl_q[0]};
				PFDEC_REG_OUT: rdata_q <= {9'h000, outr_q};
				PFDEC_REG_MAP: rdata_q <= {10'h000, map_q};
				PFDEC_REG_MOD: rdata_q <= {4'h0, mod_q};
				PFDEC_REG_DUTY: rdata_q <= {4'h0, duty_q};
				default: rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign reg_rdata = rdata_q;
	assign pwm_out = pwm_out_q;
	assign pwm_oe = pwm_oe_q;
	assign cycle_start = cs_q;
	assign use_odd_values = odd_q;
	assign fault1_irq = irq_q[0];
	assign fault4_irq = irq_q[1];
	assign reload_irq = rirq_q;

	// dead-time lives downstream; this block only passes steady gating.

	a_flag_on_rise: assert property (@(posedge clk) disable iff (!arst_n)
		rise[0] |=> flag_q[0]) else $error("flag 1 not set after filtered rise");
	a_flag_hold: assert property (@(posedge clk) disable iff (!arst_n)
		(flag_q[1] && !ack[1]) |=> flag_q[1]) else $error("flag 4 cleared without acknowledge");
	a_filter_two: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(lvl_q[0]) |-> $past(filt_in[0], 1) && $past(filt_in[0], 2)) else $error("level set without two samples");
	a_irq_needs_en: assert property (@(posedge clk) disable iff (!arst_n)
		!fault_irq_enable[0] |=> !irq_q[0]) else $error("irq latch kept with enable clear");
	a_irq_latch: assert property (@(posedge clk) disable iff (!arst_n)
		(rise[1] && fault_irq_enable[1]) |=> fault4_irq) else $error("irq not latched");
	a_fault_disables: assert property (@(posedge clk) disable iff (!arst_n)
		(rise[0] && map_q == 6'h3f) |=> ##1 (pwm_out == 6'h00)) else $error("outputs not forced off");
	a_soft_noflag: assert property (@(posedge clk) disable iff (!arst_n)
		(ctrl_q[PFDEC_CTL_BANK_X_SOFT_DISABLE] && !rise[0] && !flag_q[0]) |=> !flag_q[0]) else $error("soft disable set a flag");
	a_enable_reload: assert property (@(posedge clk) disable iff (!arst_n)
		en_rise |=> ctrl_q[PFDEC_CTL_RFLAG] && cycle_start) else $error("no reload on first enable");
	a_tristate: assert property (@(posedge clk) disable iff (!arst_n)
		(!module_enable_bit && !manual_output_override) |=> pwm_oe == 6'h00) else $error("pins driven while off");
	a_auto_hold: assert property (@(posedge clk) disable iff (!arst_n)
		(dis_q[0] && fault_reenable_select[0] && lvl_q[0]) |=> dis_q[0]) else $error("auto re-enable with fault high");
	a_flag4_on_rise: assert property (@(posedge clk) disable iff (!arst_n)
		rise[1] |=> flag_q[1])
		else $error("flag 4 not set after filtered rise");
	a_ack_clears: assert property (@(posedge clk) disable iff (!arst_n)
		(ack[0] && !rise[0]) |=> !flag_q[0])
		else $error("flag 1 kept after acknowledge");
	a_irq1_latch: assert property (@(posedge clk) disable iff (!arst_n)
		(rise[0] && fault_irq_enable[0]) |=> fault1_irq)
		else $error("irq 1 not latched");
	a_irq_ack_clear: assert property (@(posedge clk) disable iff (!arst_n)
		(ack[1] && !rise[1]) |=> !irq_q[1])
		else $error("irq 4 kept after acknowledge");
	a_irq4_needs_en: assert property (@(posedge clk) disable iff (!arst_n)
		!fault_irq_enable[1] |=> !irq_q[1])
		else $error("irq 4 latch kept with enable clear");
	a_port_masked: assert property (@(posedge clk) disable iff (!arst_n)
		fault_shared_port_dir[0] |=> !$rose(lvl_q[0]))
		else $error("fault seen on output-configured pin");
	a_filter_two4: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(lvl_q[1]) |-> $past(filt_in[1], 1) && $past(filt_in[1], 2))
		else $error("level 4 set without two samples");
	a_level_drop: assert property (@(posedge clk) disable iff (!arst_n)
		(filt_q[0] == PFDEC_F_HIGH && !filt_in[0]) |=> !lvl_q[0])
		else $error("level 1 kept after low sample");
	a_manual_hold: assert property (@(posedge clk) disable iff (!arst_n)
		(dis_q[0] && !fault_reenable_select[0] && flag_q[0]) |=> dis_q[0])
		else $error("manual re-enable before acknowledge");
	a_manual4_low: assert property (@(posedge clk) disable iff (!arst_n)
		(dis_q[1] && !fault_reenable_select[1] && filt_in[1]) |=> dis_q[1])
		else $error("input 4 re-enabled with pin high");
	a_wait_cycle: assert property (@(posedge clk) disable iff (!arst_n)
		(dis_q[0] && !eval_pt) |=> dis_q[0])
		else $error("re-enable outside cycle start");
	a_override_eval: assert property (@(posedge clk) disable iff (!arst_n)
		(manual_output_override && dis_q[0] && clr_ok[0] && !rise[0]) |=> !dis_q[0])
		else $error("override re-enable not immediate");
	a_soft_force: assert property (@(posedge clk) disable iff (!arst_n)
		(ctrl_q[PFDEC_CTL_BANK_X_SOFT_DISABLE] && map_q == 6'h3f) |=> ##1 (pwm_out == 6'h00))
		else $error("soft disable did not force outputs");
	a_soft_hold: assert property (@(posedge clk) disable iff (!arst_n)
		(dsoft_q[1] && !eval_pt) |=> dsoft_q[1])
		else $error("soft disable released outside cycle start");
	a_enable_oe: assert property (@(posedge clk) disable iff (!arst_n)
		module_enable_bit |=> pwm_oe == 6'h3f)
		else $error("pins not driven while enabled");
	a_counter_stop: assert property (@(posedge clk) disable iff (!arst_n)
		!module_enable_bit |=> cnt_q == CNT_W'(0))
		else $error("counter runs while disabled");
	a_load_permit: assert property (@(posedge clk) disable iff (!arst_n)
		(load_now && !ctrl_q[PFDEC_CTL_BUFFERED_LOAD_PERMIT]) |=> $stable(mod_act_q) && $stable(duty_act_q))
		else $error("values loaded without permit");
	a_rflag_kept: assert property (@(posedge clk) disable iff (!arst_n)
		(!module_enable_bit && ctrl_q[PFDEC_CTL_RFLAG] && !wr_ctrl) |=> ctrl_q[PFDEC_CTL_RFLAG])
		else $error("reload flag lost while disabled");
	a_odd_first: assert property (@(posedge clk) disable iff (!arst_n)
		(en_rise && ctrl_q[PFDEC_CTL_COMPL] && ctrl_q[PFDEC_CTL_CSENSE]) |=> use_odd_values)
		else $error("odd values not selected on first cycle");
endmodule : pfdec_top
`default_nettype wire

/* dv/pfdec_fault_src.sv */
// Fault source model driving one fault pin of the PWM fault block
`default_nettype none
module pfdec_fault_src (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Bench requests
	input wire logic hold_high,
	input wire logic glitch,
	// Fault pin
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pin_q;
	// A glitch is a single clock high, too short to pass the filter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= hold_high | (glitch & ~pin_q);
		end
	end
	assign pin = pin_q;
endmodule : pfdec_fault_src
`default_nettype wire

/* dv/pfdec_top_test.sv */
// Self-checking bench for the PWM fault, disable and enable control block
`default_nettype none
module pfdec_top_test
	import pfdec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [1:0] port_dir = 2'h0;
	logic [5:0] gen = 6'h00;
	logic [5:0] bits;
	logic f1_hold = 1'b0, f4_hold = 1'b0, f1_gl = 1'b0;
	logic f1_pin, f4_pin, cyc, odd, irq1, irq4, rirq;
	logic [5:0] pwm_out, pwm_oe;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int seed = 78819;
	always #2.5 clk = ~clk;
	pfdec_fault_src src1_u (.clk(clk), .arst_n(arst_n), .hold_high(f1_hold), .glitch(f1_gl), .pin(f1_pin));
	pfdec_fault_src src4_u (.clk(clk), .arst_n(arst_n), .hold_high(f4_hold), .glitch(1'b0), .pin(f4_pin));
	pfdec_top #(.CNT_W(12)) dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault1_pin(f1_pin), .fault4_pin(f4_pin),
		.fault_shared_port_dir(port_dir), .gen_pwm(gen), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
		.cycle_start(cyc), .use_odd_values(odd), .fault1_irq(irq1), .fault4_irq(irq4), .reload_irq(rirq));
	// All six outputs are killed by either bank because the map is written all ones
	function automatic logic [5:0] exp_pins(input logic [5:0] g, input logic kill);
		return kill ? 6'h00 : g;
	endfunction : exp_pins
	task automatic final_report;
		if (n_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report
	task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t reg got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_pin(input logic [5:0] got, input logic [5:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t pin got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_pin
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk_reg(reg_rdata, exp);
	endtask : rd_chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 4000) begin
			n_errors++;
			final_report();
		end
	end
	initial begin
		tick(5);
		arst_n <= 1'b1;
		chk_pin(pwm_oe, 6'h00);
		rd_chk(PFDEC_REG_FSTAT, 16'h0000);
		rd_chk(PFDEC_REG_FACK, 16'h0000);
		@(posedge clk);
		gen <= 6'($random(seed)) | 6'h01;
		bits <= 6'($random(seed)) | 6'h01;
		wr(PFDEC_REG_MOD, 16'h0004);
		wr(PFDEC_REG_MAP, 16'h003f);
		wr(PFDEC_REG_FCTL, 16'h000a);
		tick(1);
		chk_pin({5'h00, rirq}, 6'h00);
		wr(PFDEC_REG_CTRL, 16'h0007);
		tick(12);
		chk_pin({5'h00, rirq}, 6'h01);
		chk_pin(pwm_oe, 6'h3f);
		chk_pin(pwm_out, exp_pins(gen, 1'b0));
		rd_chk(PFDEC_REG_CTRL, 16'h000d);
		wr(PFDEC_REG_FSTAT, 16'h000f);
		rd_chk(PFDEC_REG_FSTAT, 16'h0000);
		f1_gl <= 1'b1;
		tick(1);
		f1_gl <= 1'b0;
		tick(10);
		rd_chk(PFDEC_REG_FSTAT, 16'h0000);
		f1_hold <= 1'b1;
		tick(10);
		rd_chk(PFDEC_REG_FSTAT, 16'h0003);
		chk_pin({4'h0, irq4, irq1}, 6'h01);
		chk_pin(pwm_out, exp_pins(gen, 1'b1));
		tick(12);
		chk_pin(pwm_out, exp_pins(gen, 1'b1));
		wr(PFDEC_REG_FACK, 16'h0002);
		tick(12);
		rd_chk(PFDEC_REG_FSTAT, 16'h0001);
		chk_pin({5'h00, irq1}, 6'h00);
		chk_pin(pwm_out, exp_pins(gen, 1'b0));
		f1_hold <= 1'b0;
		f4_hold <= 1'b1;
		tick(10);
		rd_chk(PFDEC_REG_FSTAT, 16'h000c);
		chk_pin({4'h0, irq4, irq1}, 6'h02);
		wr(PFDEC_REG_FACK, 16'h0008);
		tick(12);
		chk_pin({5'h00, irq4}, 6'h00);
		chk_pin(pwm_out, exp_pins(gen, 1'b1));
		f4_hold <= 1'b0;
		tick(12);
		chk_pin(pwm_out, exp_pins(gen, 1'b0));
		rd_chk(PFDEC_REG_FSTAT, 16'h0000);
		wr(PFDEC_REG_FCTL, 16'h000b);
		f1_hold <= 1'b1;
		tick(10);
		chk_pin(pwm_out, exp_pins(gen, 1'b1));
		wr(PFDEC_REG_FCTL, 16'h0009);
		tick(2);
		chk_pin({5'h00, irq1}, 6'h00);
		f1_hold <= 1'b0;
		tick(12);
		rd_chk(PFDEC_REG_FSTAT, 16'h0002);
		chk_pin(pwm_out, exp_pins(gen, 1'b0));
		wr(PFDEC_REG_FACK, 16'h0002);
		port_dir <= 2'h1;
		f1_hold <= 1'b1;
		tick(10);
		rd_chk(PFDEC_REG_FSTAT, 16'h0000);
		f1_hold <= 1'b0;
		tick(4);
		@(posedge clk);
		port_dir <= 2'h0;
		wr(PFDEC_REG_CTRL, 16'h004f);
		tick(3);
		chk_pin(pwm_out, exp_pins(gen, 1'b1));
		rd_chk(PFDEC_REG_FSTAT, 16'h0000);
		wr(PFDEC_REG_CTRL, 16'h000f);
		tick(12);
		chk_pin(pwm_out, exp_pins(gen, 1'b0));
		wr(PFDEC_REG_CTRL, 16'h000c);
		tick(4);
		chk_pin(pwm_oe, 6'h00);
		chk_pin({5'h00, rirq}, 6'h01);
		wr(PFDEC_REG_FCTL, 16'h000a);
		wr(PFDEC_REG_OUT, {10'h000, 6'h00} | 16'h0040 | {10'h000, bits});
		tick(4);
		chk_pin(pwm_oe, 6'h3f);
		chk_pin(pwm_out, bits);
		f1_hold <= 1'b1;
		tick(10);
		chk_pin(pwm_out, 6'h00);
		f1_hold <= 1'b0;
		tick(4);
		wr(PFDEC_REG_FACK, 16'h0002);
		tick(4);
		chk_pin(pwm_out, bits);
		wr(PFDEC_REG_CTRL, 16'h0031);
		tick(1);
		chk_pin({5'h00, cyc}, 6'h01);
		chk_pin({5'h00, odd}, 6'h01);
		tick(1);
		chk_pin({5'h00, cyc}, 6'h00);
		tick(4);
		chk_pin({5'h00, odd}, 6'h00);
		final_report();
	end
endmodule : pfdec_top_test
`default_nettype wire
